// ==== design/ssl_pkg.sv ====
package ssl_pkg;

  // ==========================================================
  // Store geometry
  // ==========================================================
  localparam int SSL_AW = 6;
  localparam int SSL_DEPTH = 64;
  localparam int SSL_DW = 8;

  // ==========================================================
  // Settings layout, byte addresses in the store
  // ==========================================================
  // Chip settings area: bytes 0..15; USB identity fields at 8..15
  localparam logic [5:0] SSL_CHIP_LAST = 6'h0F;
  localparam logic [5:0] SSL_USB_FIRST = 6'h08;
  localparam logic [5:0] SSL_USB_LAST = 6'h0F;
  // Control byte within the USB fields, bit 0 = serial enumeration enable
  localparam logic [5:0] SSL_SER_CTL_ADDR = 6'h08;
  localparam int SSL_SER_EN_BIT = 0;
  // Serial number bytes 12..15
  localparam logic [5:0] SSL_SERIAL_FIRST = 6'h0C;
  localparam logic [5:0] SSL_LAST_ADDR = 6'h3F;

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [7:0] SSL_SER_CTL_RST = 8'h00;
  localparam logic [7:0] SSL_BYTE_RST = 8'h00;
  // Access-protection unlock key; value arbitrary
  localparam logic [7:0] SSL_UNLOCK_KEY = 8'hA5;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int SSL_CLK_MHZ = 250;
  localparam int SSL_GLITCH_NS = 100;
  localparam int SSL_GLITCH_CYC = (SSL_GLITCH_NS * SSL_CLK_MHZ + 999) / 1000;
  localparam int SSL_FILT_W = 5;
  localparam logic [4:0] SSL_FILT_MAX = 5'(SSL_GLITCH_CYC);

  // ==========================================================
  // Commands and states
  // ==========================================================
  typedef enum logic [1:0] {
    SSL_SEL_SRAM = 2'h0,
    SSL_SEL_FLASH = 2'h1
  } ssl_sel_type;

  typedef struct packed {
    logic valid;
    logic write;
    ssl_sel_type sel;
    logic [5:0] addr;
    logic [7:0] wdata;
  } ssl_req_type;

  typedef struct packed {
    logic valid;
    logic denied;
    logic [7:0] rdata;
  } ssl_rsp_type;

  typedef enum logic [2:0] {
    SSL_ST_LOAD = 3'b001,
    SSL_ST_IDLE = 3'b010,
    SSL_ST_RSP = 3'b100
  } ssl_state_type;

endpackage : ssl_pkg

// ==== design/ssl_rst_filter.sv ====
`timescale 1ns/1ps
module ssl_rst_filter
  import ssl_pkg::*;
(
  input wire logic clk,
  input wire logic por_n,
  input wire logic pin_rst_n,
  output logic rst_n
);

  logic [SSL_FILT_W-1:0] cnt_q, cnt_d;
  logic rst_n_q, rst_n_d;

  // ==========================================================
  // Glitch filter on the reset pin
  // ==========================================================
  always_comb
  begin
    cnt_d = cnt_q;
    rst_n_d = rst_n_q;
    if (pin_rst_n)
    begin
      cnt_d = '0;
      rst_n_d = 1'b1;
    end
    else if (cnt_q >= SSL_FILT_MAX)
      rst_n_d = 1'b0;
    else
      cnt_d = cnt_q + 5'h01;
  end

  // Power-on pulse forces reset regardless of filter state
  always_ff @(posedge clk or negedge por_n)
  begin
    if (!por_n)
    begin
      cnt_q <= '0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      rst_n_q <= rst_n_d;
    end
  end

  assign rst_n = rst_n_q;

endmodule : ssl_rst_filter

// ==== design/ssl_settings_store.sv ====
`timescale 1ns/1ps
// Contract
// - After reset the flash settings are copied into the SRAM copy.
// - After loading, the SRAM copy is writable through HID commands.
// - Host reads and writes both flash and SRAM via one port.
// - Store manages loading and modification and protects writes.
// - USB identity bytes stay in flash only, skipped during copy.
// - Factory default: serial number not presented at enumeration.
// - A unique serial number is held and user-replaceable.
// - Serial enumeration enable is user-changeable and drives enumeration.
// - Reset pin low resets; short glitches are filtered out.
// - Power-on pulse puts the device into its initial state.
// - Settings hold descriptors, IDs, pin functions, converter, clock.
module ssl_settings_store
  import ssl_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic por_n,
  input ssl_pkg::ssl_req_type req,
  output logic req_ready,
  output ssl_pkg::ssl_rsp_type rsp,
  input wire logic [7:0] unlock_key,
  output logic load_done,
  output logic serial_enum_en,
  output logic [31:0] serial_number,
  output logic [7:0] pin_func,
  output logic [7:0] dac_cfg,
  output logic [7:0] adc_cfg,
  output logic [7:0] clk_out_cfg
);
  import ssl_pkg::*;

  logic dev_rst_n;

  // Reset pin filtered and merged with power-on pulse
  ssl_rst_filter u_filt (
    .clk(clk),
    .por_n(por_n),
    .pin_rst_n(reset_n),
    .rst_n(dev_rst_n)
  );

  // ==========================================================
  // Storage arrays
  // ==========================================================
  // Flash image holds descriptors, IDs, pin functions, ADC/DAC and
  // clock output bytes; reset of flash models factory contents.
  logic [7:0] flash_q [SSL_DEPTH];
  logic [7:0] sram_q [SSL_DEPTH];

  ssl_state_type state_q, state_d;
  logic [5:0] ptr_q, ptr_d;
  ssl_rsp_type rsp_q, rsp_d;
  logic we_flash, we_sram;
  logic [5:0] waddr;
  logic [7:0] wbyte;
  logic key_ok;
  logic usb_hit;
  logic to_flash;
  logic [7:0] rd_byte;

  function automatic logic is_usb(input logic [5:0] a);
    is_usb = (a >= SSL_USB_FIRST) && (a <= SSL_USB_LAST);
  endfunction : is_usb

  // ==========================================================
  // Host access decode
  // ==========================================================
  // The key is compared live, so it must stand with the request
  assign key_ok = (unlock_key == SSL_UNLOCK_KEY);
  assign usb_hit = is_usb(req.addr);
  assign to_flash = (req.sel == SSL_SEL_FLASH);

  // USB bytes live only in flash; their SRAM cells are never
  // loaded, so an SRAM read there answers from flash, not junk.
  always_comb
  begin
    rd_byte = sram_q[req.addr];
    if (to_flash || usb_hit)
      rd_byte = flash_q[req.addr];
  end

  // ==========================================================
  // Shared array write port
  // ==========================================================
  // Loader owns the port during the copy, the host afterwards
  always_comb
  begin
    waddr = req.addr;
    wbyte = req.wdata;
    if (state_q == SSL_ST_LOAD)
    begin
      waddr = ptr_q;
      wbyte = flash_q[ptr_q];
    end
  end

  // ==========================================================
  // Loader and command sequencer
  // ==========================================================
  always_comb
  begin
    state_d = state_q;
    ptr_d = ptr_q;
    rsp_d = rsp_q;
    we_flash = 1'b0;
    we_sram = 1'b0;
    rsp_d.valid = 1'b0;
    case (state_q)
      SSL_ST_LOAD:
      begin
        we_sram = !is_usb(ptr_q);
        ptr_d = ptr_q + 6'h01;
        if (ptr_q == SSL_LAST_ADDR)
          state_d = SSL_ST_IDLE;
      end
      SSL_ST_IDLE:
      begin
        if (req.valid)
        begin
          rsp_d.denied = 1'b0;
          rsp_d.rdata = SSL_BYTE_RST;
          if (req.write)
          begin
            // Flash writes need the key; SRAM copy stays open except the USB bytes
            if (to_flash)
            begin
              if (key_ok)
                we_flash = 1'b1;
              else
                rsp_d.denied = 1'b1;
            end
            else if (usb_hit)
              rsp_d.denied = 1'b1;
            else
              we_sram = 1'b1;
          end
          else
            rsp_d.rdata = rd_byte;
          state_d = SSL_ST_RSP;
        end
      end
      SSL_ST_RSP:
      begin
        rsp_d.valid = 1'b1;
        state_d = SSL_ST_IDLE;
      end
      default:
        state_d = SSL_ST_LOAD;
    endcase
  end

  // ==========================================================
  // Sequencer registers
  // ==========================================================
  always_ff @(posedge clk or negedge dev_rst_n)
  begin
    if (!dev_rst_n)
    begin
      state_q <= SSL_ST_LOAD;
      ptr_q <= '0;
      rsp_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      ptr_q <= ptr_d;
      rsp_q <= rsp_d;
    end
  end

  // ==========================================================
  // Array write ports
  // ==========================================================
  // The SRAM array carries no reset so it can map to memory; all
  // but its USB bytes are rewritten by the loader before any access.
  always_ff @(posedge clk)
  begin
    if (we_sram)
      sram_q[waddr] <= wbyte;
  end

  // Flash only comes up at factory value on power-on, not pin reset
  always_ff @(posedge clk or negedge por_n)
  begin
    if (!por_n)
    begin
      for (int i = 0; i < SSL_DEPTH; i++)
        flash_q[i] <= SSL_BYTE_RST;
      flash_q[SSL_SER_CTL_ADDR] <= SSL_SER_CTL_RST;
    end
    else if (we_flash)
      flash_q[waddr] <= wbyte;
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  logic [7:0] ser_ctl;
  assign ser_ctl = flash_q[SSL_SER_CTL_ADDR];

  assign req_ready = (state_q == SSL_ST_IDLE);
  assign rsp = rsp_q;
  assign load_done = (state_q != SSL_ST_LOAD);
  // Enumeration reads USB fields straight from flash
  assign serial_enum_en = ser_ctl[SSL_SER_EN_BIT];
  assign serial_number = {flash_q[SSL_SERIAL_FIRST + 6'h03],
                          flash_q[SSL_SERIAL_FIRST + 6'h02],
                          flash_q[SSL_SERIAL_FIRST + 6'h01],
                          flash_q[SSL_SERIAL_FIRST]};

  // ==========================================================
  // Working configuration from the SRAM copy
  // ==========================================================
  // Host edits act at once; flash edits only after the next load
  assign pin_func = sram_q[0];
  assign dac_cfg = sram_q[1];
  assign adc_cfg = sram_q[2];
  assign clk_out_cfg = sram_q[3];

endmodule : ssl_settings_store

// ==== sim/ssl_host_model.sv ====
`timescale 1ns/1ps
module ssl_host_model
  import ssl_pkg::*;
(
  input wire logic clk,
  input wire logic req_ready,
  input ssl_pkg::ssl_rsp_type rsp,
  output ssl_pkg::ssl_req_type req,
  output logic [7:0] unlock_key
);
  initial
  begin
    req = '0;
    unlock_key = 8'h00;
  end
  // ==========================
  // One command, held until taken
  task automatic xfer(input logic w, input ssl_sel_type s,
    input logic [5:0] a, input logic [7:0] d, input logic [7:0] k,
    output ssl_rsp_type r);
    logic took;
    logic seen;
    took = 1'b0;
    seen = 1'b0;
    @(posedge clk);
    req <= '{1'b1, w, s, a, d};
    unlock_key <= k;
    for (int n = 0; n < 300 && !took; n++)
    begin
      @(posedge clk);
      took = req_ready;
    end
    // Released lines show junk so stale values cannot pass
    req <= ssl_req_type'({1'b0, ~req[16:0]});
    unlock_key <= ~k;
    for (int n = 0; n < 8 && !seen; n++)
    begin
      @(posedge clk);
      #1;
      seen = rsp.valid;
    end
    // A missed handshake poisons the answer so the bench counts it
    r = 'x;
    if (took && seen)
      r = rsp;
  endtask : xfer
endmodule : ssl_host_model

// ==== sim/ssl_store_asserts.sv ====
`timescale 1ns/1ps
module ssl_store_asserts
  import ssl_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic por_n,
  input ssl_pkg::ssl_req_type req,
  input wire logic req_ready,
  input ssl_pkg::ssl_rsp_type rsp,
  input wire logic [7:0] unlock_key,
  input wire logic load_done,
  input wire logic serial_enum_en,
  input wire logic [7:0] pin_func
);
  logic tk;
  logic wr;
  assign tk = req.valid && req_ready;
  assign wr = tk && req.write;
  default clocking @(posedge clk); endclocking
  default disable iff (!por_n || !reset_n);
  // ==========================
  // Handshake and protection
  a_load_gate: assert property (!load_done |-> !req_ready)
    else $error("ready during load");
  a_rsp_time: assert property (tk |-> ##2 rsp.valid)
    else $error("answer late");
  a_rsp_cause: assert property (rsp.valid |-> $past(tk, 2))
    else $error("answer without request");
  a_ready_gap: assert property (tk |=> !req_ready ##1 req_ready)
    else $error("ready spacing wrong");
  a_usb_deny: assert property (wr && req.sel == SSL_SEL_SRAM
    && req.addr inside {[SSL_USB_FIRST:SSL_USB_LAST]} |-> ##2 rsp.denied)
    else $error("usb byte written in sram");
  a_key_deny: assert property (wr && req.sel == SSL_SEL_FLASH
    && unlock_key != SSL_UNLOCK_KEY |-> ##2 rsp.denied)
    else $error("flash write without key");
  a_sram_pin: assert property (wr && req.sel == SSL_SEL_SRAM
    && req.addr == 6'h00 |-> ##2 pin_func == $past(req.wdata, 2))
    else $error("pin function not updated");
  a_factory_off: assert property ($rose(por_n) |-> !serial_enum_en)
    else $error("serial enabled after power-on");
  // Short pin pulses must not disturb a loaded store
  a_glitch_ign: assert property (disable iff (!por_n)
    $fell(reset_n) && load_done ##1 !reset_n [*7] |-> load_done)
    else $error("glitch caused reset");
endmodule : ssl_store_asserts

bind ssl_settings_store ssl_store_asserts ssl_store_asserts_i (.clk,
  .reset_n, .por_n, .req, .req_ready, .rsp, .unlock_key, .load_done,
  .serial_enum_en, .pin_func);

// ==== sim/test_settings_store_loader.sv ====
`timescale 1ns/1ps
module test_settings_store_loader;
  import ssl_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b1;
  logic por_n = 1'b0;
  ssl_req_type req;
  ssl_rsp_type rsp;
  ssl_rsp_type r;
  logic req_ready, load_done, serial_enum_en;
  logic [7:0] unlock_key, pin_func, dac_cfg, adc_cfg, clk_out_cfg;
  logic [31:0] serial_number;
  int errors = 0;
  int samples_checked = 0;
  always #2 clk = ~clk;
  ssl_settings_store ssl_settings_store_i (.clk, .reset_n, .por_n, .req,
    .req_ready, .rsp, .unlock_key, .load_done, .serial_enum_en,
    .serial_number, .pin_func, .dac_cfg, .adc_cfg, .clk_out_cfg);
  ssl_host_model ssl_host_model_i (.clk, .req_ready, .rsp, .req,
    .unlock_key);
  task automatic check(input string nm, input logic [31:0] seen,
    input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // Reads expect d back
  task automatic acc(input logic w, input ssl_sel_type s,
    input logic [5:0] a, input logic [7:0] d, input logic [7:0] k,
    input logic dn);
    ssl_host_model_i.xfer(w, s, a, d, k, r);
    check("denied", r.denied, dn);
    if (!w) check("rdata", r.rdata, d);
  endtask : acc
  task automatic finish_test;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test
  initial
  begin
    #8000;
    errors++;
    finish_test();
  end
  // ==========================
  // Main sequence
  initial
  begin
    repeat (4) @(posedge clk);
    por_n <= 1'b1;
    @(posedge clk);
    #1;
    check("load_done", load_done, 1'h0);
    check("enum_en", serial_enum_en, 1'h0);
    acc(1'h0, SSL_SEL_SRAM, 6'h00, 8'h00, 8'h00, 1'h0);
    acc(1'h1, SSL_SEL_SRAM, 6'h00, 8'h3C, 8'h00, 1'h0);
    acc(1'h0, SSL_SEL_SRAM, 6'h00, 8'h3C, 8'h00, 1'h0);
    check("pin_func", pin_func, 8'h3C);
    acc(1'h1, SSL_SEL_SRAM, 6'h01, 8'h21, 8'h00, 1'h0);
    acc(1'h1, SSL_SEL_SRAM, 6'h02, 8'h22, 8'h00, 1'h0);
    acc(1'h1, SSL_SEL_SRAM, 6'h03, 8'h23, 8'h00, 1'h0);
    check("dac_cfg", dac_cfg, 8'h21);
    check("adc_cfg", adc_cfg, 8'h22);
    check("clk_out_cfg", clk_out_cfg, 8'h23);
    acc(1'h1, SSL_SEL_SRAM, 6'h08, 8'h11, 8'h00, 1'h1);
    acc(1'h1, SSL_SEL_FLASH, 6'h00, 8'h5A, 8'h00, 1'h1);
    acc(1'h0, SSL_SEL_FLASH, 6'h00, 8'h00, 8'h00, 1'h0);
    acc(1'h1, SSL_SEL_FLASH, 6'h00, 8'h5A, SSL_UNLOCK_KEY, 1'h0);
    acc(1'h0, SSL_SEL_FLASH, 6'h00, 8'h5A, 8'h00, 1'h0);
    acc(1'h1, SSL_SEL_FLASH, 6'h08, 8'h01, SSL_UNLOCK_KEY, 1'h0);
    check("enum_en", serial_enum_en, 1'h1);
    acc(1'h0, SSL_SEL_SRAM, 6'h08, 8'h01, 8'h00, 1'h0);
    for (int i = 0; i < 4; i++)
      acc(1'h1, SSL_SEL_FLASH, 6'(6'h0C + i), 8'(8'h10 + i),
        SSL_UNLOCK_KEY, 1'h0);
    check("serial", serial_number, 32'h1312_1110);
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check("load_done", load_done, 1'h1);
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (30) @(posedge clk);
    #1;
    check("load_done", load_done, 1'h0);
    @(posedge clk);
    reset_n <= 1'b1;
    acc(1'h0, SSL_SEL_SRAM, 6'h00, 8'h5A, 8'h00, 1'h0);
    check("pin_func", pin_func, 8'h5A);
    check("dac_cfg", dac_cfg, SSL_BYTE_RST);
    check("enum_en", serial_enum_en, 1'h1);
    check("serial", serial_number, 32'h1312_1110);
    finish_test();
  end
endmodule : test_settings_store_loader
